/* File: logic/fcsr_core.sv */
// command core: reset, suspend/resume, power-down, id and special reads
module fcsr_core #(
  parameter logic [7:0] DEVICE_ID = 8'h5A  // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] sioIn,
  output logic [3:0] sioOut,
  output logic [3:0] sioOe,
  input wire logic qpiMode,
  input wire logic opRunning,
  input wire fcsr_pkg::fcsr_opkind_type opKind,
  input wire logic [7:0] memData,
  output logic [23:0] memAddr,
  output fcsr_pkg::fcsr_status_type status,
  output fcsr_pkg::fcsr_fwd_type fwd,
  output logic engineHold,
  output logic softReset,
  output logic [7:0] readParam
);
  import fcsr_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic csMeta;
    logic csS;
    logic csD;
    logic sclkMeta;
    logic sclkS;
    logic sclkD;
    logic [3:0] sioMeta;
    logic [3:0] sioS;
    fcsr_frame_type frame;
    fcsr_pend_type pend;
    fcsr_kind_type kind;
    logic [7:0] bitCnt;
    logic [7:0] dumEnd;
    logic [31:0] shIn;
    logic [7:0] shOut;
    logic [2:0] outLeft;
    logic [23:0] addr;
    logic [3:0] sioOut;
    logic [3:0] sioOe;
    logic rstArm;
    logic write_in_progress_flag;
    logic susProg;
    logic susErase;
    logic deepPd;
    logic dpRel;
    logic hold;
    logic softRst;
    logic refuse;
    logic [11:0] rstCnt;
    logic [11:0] dpCnt;
    logic [11:0] susCnt;
    logic [11:0] susAge;
    logic [7:0] readParam;
    fcsr_fwd_type fwd;
  } fcsr_state_type;

  localparam fcsr_state_type ST_ZERO = fcsr_state_type'('0);

  fcsr_state_type st_ff;
  fcsr_state_type nxt_st;
  fcsr_state_type rs;
  logic sclkRise, sclkFall, csFall, csRise, busy, suspended;
  logic doReset, secBad, dataLoad, eraseOp, progOp;
  logic [7:0] step, cntNew, opc, outByte;
  logic [31:0] shNew;
  logic [23:0] wrapMask;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    rs = ST_ZERO;
    doReset = 1'b0;
    dataLoad = 1'b0;
    opc = 8'h00;
    outByte = 8'h00;
    // pin synchronisers
    nxt_st.csMeta = csN;
    nxt_st.csS = st_ff.csMeta;
    nxt_st.csD = st_ff.csS;
    nxt_st.sclkMeta = sclk;
    nxt_st.sclkS = st_ff.sclkMeta;
    nxt_st.sclkD = st_ff.sclkS;
    nxt_st.sioMeta = sioIn;
    nxt_st.sioS = st_ff.sioMeta;
    nxt_st.softRst = 1'b0;
    nxt_st.fwd.valid = 1'b0;
    nxt_st.fwd.blocked = 1'b0;

    sclkRise = st_ff.sclkS & ~st_ff.sclkD;
    sclkFall = ~st_ff.sclkS & st_ff.sclkD;
    csFall = ~st_ff.csS & st_ff.csD;
    csRise = st_ff.csS & ~st_ff.csD;
    busy = (st_ff.rstCnt != 12'h000) || (st_ff.dpCnt != 12'h000);
    suspended = st_ff.susProg | st_ff.susErase;
    step = qpiMode ? 8'h04 : 8'h01;
    shNew = qpiMode ? {st_ff.shIn[27:0], st_ff.sioS}
                    : {st_ff.shIn[30:0], st_ff.sioS[0]};
    // opcode candidate, so the suspend filters see the byte being decoded
    opc = shNew[7:0];
    cntNew = st_ff.bitCnt + step;
    wrapMask = (WRAP_BASE_BYTES << st_ff.readParam[RP_WRAP_LSB +: 2])
               - 24'h000001;
    secBad = (st_ff.addr[23:16] != 8'h00)
          || (st_ff.addr[15:12] < SEC_REG_FIRST)
          || (st_ff.addr[15:12] > SEC_REG_LAST)
          || (st_ff.addr[11:10] != 2'b00);
    eraseOp = (opc == OPC_WRITE_STATUS) || (opc == OPC_SEC_ERASE)
           || (opc == OPC_ERASE_SECTOR) || (opc == OPC_ERASE_32K)
           || (opc == OPC_ERASE_64K) || (opc == OPC_ERASE_CHIP_A)
           || (opc == OPC_ERASE_CHIP_B);
    progOp = (opc == OPC_SEC_PROG) || (opc == OPC_PAGE_PROG)
          || (opc == OPC_QUAD_PROG);

    // timers
    if (st_ff.rstCnt != 12'h000) begin
      nxt_st.rstCnt = st_ff.rstCnt - 12'h001;
    end
    if (st_ff.dpCnt != 12'h000) begin
      nxt_st.dpCnt = st_ff.dpCnt - 12'h001;
      if (st_ff.dpCnt == 12'h001) begin
        nxt_st.deepPd = ~st_ff.dpRel;
      end
    end
    if (st_ff.susCnt != 12'h000) begin
      nxt_st.susCnt = st_ff.susCnt - 12'h001;
    end
    // cycles spent suspended while still busy, watched by a check
    nxt_st.susAge = (suspended && st_ff.write_in_progress_flag) ? st_ff.susAge + 12'h001
                                             : 12'h000;
    // busy drops at the end of suspend latency, returns after resume delay
    if (suspended) begin
      nxt_st.write_in_progress_flag = (st_ff.susCnt > 12'h001);
    end else begin
      nxt_st.write_in_progress_flag = opRunning & (st_ff.susCnt <= 12'h001);
    end

    // ---------------------------------------------------------------
    // frame reception
    // ---------------------------------------------------------------
    if (st_ff.csS) begin
      nxt_st.frame = FR_IDLE;
      nxt_st.sioOe = 4'h0;
    end
    if (csFall) begin
      nxt_st.frame = busy ? FR_IGNORE : FR_OPC;
      nxt_st.bitCnt = 8'h00;
      nxt_st.shIn = 32'h00000000;
      nxt_st.pend = PEND_NONE;
    end else if (!st_ff.csS && sclkRise) begin
      nxt_st.shIn = shNew;
      nxt_st.bitCnt = cntNew;
      case (st_ff.frame)
        FR_OPC: begin
          if (cntNew == OPC_BITS) begin
            opc = shNew[7:0];
            nxt_st.frame = FR_IGNORE;
            nxt_st.rstArm = 1'b0;
            if (opc == OPC_RESET && st_ff.rstArm) begin
              doReset = 1'b1;
            end else if (opc == OPC_EN_RESET) begin
              nxt_st.frame = FR_CMDEND;
              nxt_st.pend = PEND_ENRST;
            end else if (st_ff.deepPd) begin
              if (opc == OPC_RELEASE_ID) begin
                nxt_st.frame = FR_CMDEND;
                nxt_st.pend = PEND_RELEASE;
              end
            end else begin
              case (opc)
                OPC_SUSPEND: begin
                  nxt_st.frame = FR_CMDEND;
                  nxt_st.pend = PEND_SUSPEND;
                end
                OPC_RESUME: begin
                  nxt_st.frame = FR_CMDEND;
                  nxt_st.pend = PEND_RESUME;
                end
                OPC_DEEP_PD: begin
                  nxt_st.frame = FR_CMDEND;
                  nxt_st.pend = PEND_DEEP_PD;
                end
                OPC_RELEASE_ID: begin
                  if (!st_ff.write_in_progress_flag) begin
                    nxt_st.frame = FR_DUMMY;
                    nxt_st.kind = KIND_ID;
                    nxt_st.dumEnd = ID_DUMMY_END;
                  end
                end
                OPC_SEC_READ: begin
                  nxt_st.frame = FR_ADDR;
                  nxt_st.kind = KIND_SEC;
                  nxt_st.dumEnd = SEC_DUMMY_END;
                end
                OPC_WRAP_READ: begin
                  if (qpiMode) begin
                    nxt_st.frame = FR_ADDR;
                    nxt_st.kind = KIND_WRAP;
                    nxt_st.dumEnd = ADDR_END + (fcsr_dummy_clocks(
                      st_ff.readParam[RP_DUMMY_LSB +: 2]) << 2);
                  end
                end
                OPC_SET_PARAM: begin
                  if (qpiMode) begin
                    nxt_st.frame = FR_PARAM;
                  end
                end
                default: begin
                  nxt_st.fwd.opcode = opc;
                  if ((st_ff.susProg && (eraseOp || progOp))
                      || (st_ff.susErase && eraseOp)) begin
                    nxt_st.fwd.blocked = 1'b1;
                  end else begin
                    nxt_st.fwd.valid = 1'b1;
                  end
                end
              endcase
            end
          end
        end
        FR_ADDR: begin
          if (cntNew == ADDR_END) begin
            nxt_st.addr = shNew[23:0];
            nxt_st.frame = FR_DUMMY;
          end
        end
        FR_DUMMY: begin
          if (cntNew == st_ff.dumEnd) begin
            nxt_st.frame = FR_DATA;
            nxt_st.outLeft = 3'd0;
          end
        end
        FR_PARAM: begin
          if (cntNew == PARAM_END) begin
            nxt_st.readParam = shNew[7:0];
            nxt_st.frame = FR_IGNORE;
          end
        end
        FR_CMDEND: nxt_st.frame = FR_IGNORE;
        default: ;
      endcase
    end else if (!st_ff.csS && sclkFall && st_ff.frame == FR_DATA) begin
      // ---------------------------------------------------------------
      // data out on falling edges, MSB first
      // ---------------------------------------------------------------
      if (st_ff.outLeft == 3'd0) begin
        dataLoad = 1'b1;
        if (st_ff.kind == KIND_ID) begin
          outByte = DEVICE_ID;
        end else if (st_ff.kind == KIND_SEC && secBad) begin
          outByte = BLANK_BYTE;
        end else begin
          outByte = memData;
        end
        if (qpiMode) begin
          nxt_st.sioOut = outByte[7:4];
          nxt_st.shOut = {outByte[3:0], 4'h0};
          nxt_st.outLeft = 3'd1;
          nxt_st.sioOe = 4'hF;
        end else begin
          nxt_st.sioOut = {2'b00, outByte[7], 1'b0};
          nxt_st.shOut = {outByte[6:0], 1'b0};
          nxt_st.outLeft = 3'd7;
          nxt_st.sioOe = 4'h2;
        end
        if (st_ff.kind == KIND_SEC) begin
          nxt_st.addr = {st_ff.addr[23:10],
                         st_ff.addr[9:0] + 10'h001};
        end else if (st_ff.kind == KIND_WRAP) begin
          nxt_st.addr = (st_ff.addr & ~wrapMask)
                      | ((st_ff.addr + 24'h000001) & wrapMask);
        end
      end else begin
        if (qpiMode) begin
          nxt_st.sioOut = st_ff.shOut[7:4];
          nxt_st.shOut = {st_ff.shOut[3:0], 4'h0};
        end else begin
          nxt_st.sioOut = {2'b00, st_ff.shOut[7], 1'b0};
          nxt_st.shOut = {st_ff.shOut[6:0], 1'b0};
        end
        nxt_st.outLeft = st_ff.outLeft - 3'd1;
      end
    end

    // ---------------------------------------------------------------
    // single-opcode commands other than reset act when the frame closes
    // ---------------------------------------------------------------
    if (csRise && st_ff.frame == FR_CMDEND) begin
      case (st_ff.pend)
        PEND_ENRST: nxt_st.rstArm = 1'b1;
        PEND_SUSPEND: begin
          if (!suspended && st_ff.write_in_progress_flag
              && (opKind == OPK_PROGRAM || opKind == OPK_ERASE)) begin
            nxt_st.susProg = (opKind == OPK_PROGRAM);
            nxt_st.susErase = (opKind == OPK_ERASE);
            nxt_st.susCnt = SUSPEND_CYCLES;
          end
        end
        PEND_RESUME: begin
          if (suspended && !st_ff.write_in_progress_flag) begin
            nxt_st.susProg = 1'b0;
            nxt_st.susErase = 1'b0;
            nxt_st.susCnt = RESUME_CYCLES;
          end
        end
        PEND_DEEP_PD: begin
          if (!st_ff.write_in_progress_flag) begin
            nxt_st.dpCnt = PD_ENTRY_CYCLES;
            nxt_st.dpRel = 1'b0;
          end
        end
        PEND_RELEASE: begin
          nxt_st.dpCnt = RELEASE_CYCLES;
          nxt_st.dpRel = 1'b1;
        end
        default: ;
      endcase
    end

    // software reset: power-on values except rstCnt, refuse, softRst and frame; synchronisers kept
    if (doReset) begin
      rs.csMeta = nxt_st.csMeta;
      rs.csS = nxt_st.csS;
      rs.csD = nxt_st.csD;
      rs.sclkMeta = nxt_st.sclkMeta;
      rs.sclkS = nxt_st.sclkS;
      rs.sclkD = nxt_st.sclkD;
      rs.sioMeta = nxt_st.sioMeta;
      rs.sioS = nxt_st.sioS;
      rs.readParam = RP_RESET;
      rs.frame = FR_IGNORE;
      rs.softRst = 1'b1;
      rs.rstCnt = RESET_CYCLES;
      nxt_st = rs;
    end
    nxt_st.hold = nxt_st.susProg | nxt_st.susErase;
    nxt_st.refuse = (nxt_st.rstCnt != 12'h000) || (nxt_st.dpCnt != 12'h000);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_ZERO;
      // chip select idles high: no false edge after reset
      st_ff.csMeta <= 1'b1;
      st_ff.csS <= 1'b1;
      st_ff.csD <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sioOut = st_ff.sioOut;
  assign sioOe = st_ff.sioOe;
  assign memAddr = st_ff.addr;
  assign status = {st_ff.write_in_progress_flag, st_ff.susProg, st_ff.susErase, st_ff.deepPd,
                   st_ff.refuse};
  assign fwd = st_ff.fwd;
  assign engineHold = st_ff.hold;
  assign softReset = st_ff.softRst;
  assign readParam = st_ff.readParam;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sec_increment: assert property (dataLoad && st_ff.kind == KIND_SEC
    && st_ff.addr[9:0] != 10'h3FF |=> memAddr[9:0] ==
    $past(memAddr[9:0]) + 10'h001)
    else $error("security address did not advance");
  a_sec_wrap: assert property (dataLoad && st_ff.kind == KIND_SEC
    && st_ff.addr[9:0] == 10'h3FF |=> memAddr[9:0] == 10'h000)
    else $error("security address did not wrap");
  a_wrap_window: assert property (dataLoad && st_ff.kind == KIND_WRAP
    |=> (memAddr & ~wrapMask) == ($past(memAddr) & ~wrapMask))
    else $error("wrap read left its window");
  a_reset_refuse: assert property ($rose(softReset)
    |=> status.refuse [*8])
    else $error("commands not refused after reset");
  a_reset_clears: assert property (softReset |-> !status.susProg
    && !status.susErase && !status.deepPd
    && readParam == RP_RESET)
    else $error("reset left volatile state");
  a_suspend_gate: assert property ($rose(status.susProg | status.susErase)
    |-> $past(status.write_in_progress_flag))
    else $error("suspend accepted without busy");
  a_suspend_latency: assert property (
    st_ff.susAge <= SUSPEND_CYCLES)
    else $error("busy stuck after suspend");
  a_resume_gate: assert property ($fell(status.susProg | status.susErase)
    && !softReset |-> !$past(status.write_in_progress_flag) ##[0:20]
    st_ff.susCnt <= 12'h001)
    else $error("resume accepted while busy or too slow");
  a_resume_only: assert property ($fell(status.susProg | status.susErase)
    && !softReset |-> !engineHold)
    else $error("engine held after resume");
  a_pd_entry: assert property ($rose(status.deepPd)
    |-> $past(st_ff.dpCnt) == 12'h001 && !$past(st_ff.dpRel))
    else $error("power-down entered without delay");
  a_pd_filter: assert property (status.deepPd |-> !fwd.valid)
    else $error("command forwarded in power-down");
  a_prog_block: assert property (fwd.valid && $past(st_ff.susProg)
    |-> fwd.opcode != OPC_PAGE_PROG && fwd.opcode != OPC_SEC_PROG)
    else $error("program allowed during program suspend");

  c_soft_reset: cover property ($rose(softReset));
  c_power_down: cover property ($rose(status.deepPd));
  c_suspend: cover property ($rose(status.susErase));
  c_wrap_load: cover property (dataLoad && st_ff.kind == KIND_WRAP);
endmodule

/* File: logic/fcsr_pkg.sv */
// constants, enumerations and carrier types of the flash command core
package fcsr_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_EN_RESET = 8'h66;
  localparam logic [7:0] OPC_RESET = 8'h99;
  localparam logic [7:0] OPC_SUSPEND = 8'h75;
  localparam logic [7:0] OPC_RESUME = 8'h7A;
  localparam logic [7:0] OPC_DEEP_PD = 8'hB9;
  localparam logic [7:0] OPC_RELEASE_ID = 8'hAB;
  localparam logic [7:0] OPC_SEC_READ = 8'h48;
  localparam logic [7:0] OPC_WRAP_READ = 8'h0C;
  localparam logic [7:0] OPC_SET_PARAM = 8'hC0;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
  localparam logic [7:0] OPC_SEC_PROG = 8'h42;
  localparam logic [7:0] OPC_ERASE_SECTOR = 8'h20;
  localparam logic [7:0] OPC_ERASE_32K = 8'h52;
  localparam logic [7:0] OPC_ERASE_64K = 8'hD8;
  localparam logic [7:0] OPC_ERASE_CHIP_A = 8'hC7;
  localparam logic [7:0] OPC_ERASE_CHIP_B = 8'h60;
  localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] OPC_QUAD_PROG = 8'h32;

  // ---------------------------------------------------------------
  // frame layout in received bits
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_BITS = 8'h08;
  localparam logic [7:0] ADDR_END = 8'h20;
  localparam logic [7:0] SEC_DUMMY_END = 8'h28;
  localparam logic [7:0] ID_DUMMY_END = 8'h20;
  localparam logic [7:0] PARAM_END = 8'h10;
  localparam logic [3:0] SEC_REG_FIRST = 4'h1;
  localparam logic [3:0] SEC_REG_LAST = 4'h3;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;

  // ---------------------------------------------------------------
  // read parameter setting
  // ---------------------------------------------------------------
  localparam logic [7:0] RP_RESET = 8'h00;
  localparam int RP_DUMMY_LSB = 4;
  localparam int RP_WRAP_LSB = 0;
  localparam logic [7:0] DUMMY_CLK_SHORT = 8'h04;
  localparam logic [7:0] DUMMY_CLK_MID = 8'h06;
  localparam logic [7:0] DUMMY_CLK_LONG = 8'h08;
  localparam logic [23:0] WRAP_BASE_BYTES = 24'h000008;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_DURATION_NS = 30000;
  localparam int PD_ENTRY_DELAY_NS = 3000;
  localparam int RELEASE_DELAY_NS = 8000;
  localparam int SUSPEND_LATENCY_NS = 30000;
  localparam int RESUME_LATENCY_NS = 200;
  localparam logic [11:0] RESET_CYCLES =
    12'((RESET_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] PD_ENTRY_CYCLES =
    12'((PD_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] RELEASE_CYCLES =
    12'((RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] SUSPEND_CYCLES =
    12'(SUSPEND_LATENCY_NS / CLK_PERIOD_NS);
  localparam logic [11:0] RESUME_CYCLES =
    12'(RESUME_LATENCY_NS / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OPK_NONE = 2'b00, OPK_WRITE = 2'b01,
    OPK_PROGRAM = 2'b10, OPK_ERASE = 2'b11
  } fcsr_opkind_type;

  typedef enum logic [2:0] {
    FR_IDLE = 3'b000, FR_OPC = 3'b001, FR_ADDR = 3'b010,
    FR_DUMMY = 3'b011, FR_DATA = 3'b100, FR_PARAM = 3'b101,
    FR_CMDEND = 3'b110, FR_IGNORE = 3'b111
  } fcsr_frame_type;

  typedef enum logic [2:0] {
    PEND_NONE = 3'b000, PEND_ENRST = 3'b001, PEND_SUSPEND = 3'b010,
    PEND_RESUME = 3'b011, PEND_DEEP_PD = 3'b100, PEND_RELEASE = 3'b101
  } fcsr_pend_type;

  typedef enum logic [1:0] {
    KIND_SEC = 2'b00, KIND_WRAP = 2'b01, KIND_ID = 2'b10
  } fcsr_kind_type;

  typedef struct packed {
    logic write_in_progress_flag;
    logic susProg;
    logic susErase;
    logic deepPd;
    logic refuse;
  } fcsr_status_type;

  typedef struct packed {
    logic valid;
    logic blocked;
    logic [7:0] opcode;
  } fcsr_fwd_type;

  function automatic logic [7:0] fcsr_dummy_clocks(input logic [1:0] sel);
    case (sel)
      2'b10: fcsr_dummy_clocks = DUMMY_CLK_MID;
      2'b11: fcsr_dummy_clocks = DUMMY_CLK_LONG;
      default: fcsr_dummy_clocks = DUMMY_CLK_SHORT;
    endcase
  endfunction

endpackage

/* File: test/fcsr_host.sv */
// host model driving the flash pins
module fcsr_host (
  input wire logic clk,
  input wire logic quad,
  output logic csN,
  output logic sclk,
  output logic [3:0] sioIn,
  input wire logic [3:0] sioOut
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    sioIn = 4'h0;
  end
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  // n bits out msb first, then r bits read back; four a clock in quad mode
  task automatic frame(input logic [63:0] b, input int n, input int r,
                       output logic [15:0] rd);
    int w;
    w = quad ? 4 : 1;
    rd = 16'h0000;
    csN = 1'b0;
    for (int i = n + r - w; i >= 0; i -= w) begin
      if (i < r) sioIn = ~sioIn;
      else if (quad) sioIn = 4'(b >> (i - r));
      else sioIn[0] = b[i - r];
      half();
      sclk = 1'b1;
      if (i < r) begin
        rd = quad ? {rd[11:0], sioOut} : {rd[14:0], sioOut[1]};
      end
      half();
      sclk = 1'b0;
    end
    half();
    csN = 1'b1;
    sioIn = ~sioIn;
    half();
  endtask
endmodule

/* File: test/flash_cmd_suspend_reset_powerdown_tb_top.sv */
// self-checking bench of the flash command core
module flash_cmd_suspend_reset_powerdown_tb_top;
  import fcsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'hC3; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic opRunning = 1'b0;
  logic qpi = 1'b0;
  logic csN, sclk, engineHold, softReset;
  logic [3:0] sioIn, sioOut, sioOe;
  logic [7:0] key = 8'h00;
  logic [7:0] memData, readParam, param;
  logic [23:0] wa;
  int dum, wlen;
  int resetCount = 0;
  logic [23:0] memAddr;
  logic [15:0] rd;
  logic [1:0] sus;
  fcsr_opkind_type opKind = OPK_NONE;
  fcsr_status_type st;
  fcsr_fwd_type fwd;
  fcsr_fwd_type lastFwd = '0;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  fcsr_core #(.DEVICE_ID(ID)) dut (.clk(clk), .rst_n(rst_n), .csN(csN),
    .sclk(sclk), .sioIn(sioIn), .sioOut(sioOut), .sioOe(sioOe),
    .qpiMode(qpi), .opRunning(opRunning), .opKind(opKind),
    .memData(memData), .memAddr(memAddr), .status(st), .fwd(fwd),
    .engineHold(engineHold), .softReset(softReset),
    .readParam(readParam));
  fcsr_host host (.clk(clk), .quad(qpi), .csN(csN), .sclk(sclk),
    .sioIn(sioIn), .sioOut(sioOut));
  // array model: byte value follows its address, scrambled by a random key
  assign memData = memAddr[7:0] ^ key;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic op(input logic [7:0] c);
    host.frame(64'(c), 8, 0, rd);
  endtask
  always @(negedge clk) begin
    if (softReset === 1'b1) resetCount++;
    if (fwd.valid || fwd.blocked) lastFwd <= fwd;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(40));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    wt(1);
    chk(16'(st), 16'h0000);
    host.frame({OPC_RELEASE_ID, 24'h000000}, 32, 16, rd);
    chk(rd, {ID, ID});
    $display("test id done");
    key = 8'($urandom);
    host.frame({OPC_SEC_READ, 24'h0013FF, 8'h00}, 40, 16, rd);
    chk(rd, {8'hFF ^ key, key});
    chk(memAddr[15:0], 16'h1002);
    host.frame({OPC_SEC_READ, 24'h004000, 8'h00}, 40, 16, rd);
    chk(rd, 16'hFFFF);
    $display("test security read done");
    op(OPC_SUSPEND);
    wt(10);
    chk(16'({st.susProg, st.susErase}), 16'h0000);
    sus = ($urandom & 1) ? 2'b10 : 2'b01;
    opKind = sus[1] ? OPK_PROGRAM : OPK_ERASE;
    opRunning = 1'b1;
    wt(10);
    op(OPC_SUSPEND);
    wt(10);
    chk(16'({st.write_in_progress_flag, st.susProg, st.susErase, engineHold}),
        16'({1'b1, sus, 1'b1}));
    op(OPC_SEC_ERASE);
    chk(16'(lastFwd), 16'({2'b01, OPC_SEC_ERASE}));
    wt(3000);
    chk(16'({st.write_in_progress_flag, st.susProg, st.susErase}), 16'(sus));
    op(OPC_RESUME);
    wt(30);
    chk(16'({st.write_in_progress_flag, sus & {st.susProg, st.susErase}, engineHold}),
        16'h0008);
    $display("test suspend done");
    op(OPC_DEEP_PD);
    wt(400);
    chk(16'({st.write_in_progress_flag, st.deepPd}), 16'h0002);
    opRunning = 1'b0;
    opKind = OPK_NONE;
    host.frame({23'h0, OPC_DEEP_PD, 1'b0}, 9, 0, rd);
    wt(400);
    chk(16'(st.deepPd), 16'h0000);
    op(OPC_DEEP_PD);
    wt(250);
    chk(16'({st.deepPd, st.refuse}), 16'h0001);
    wt(100);
    chk(16'(st.deepPd), 16'h0001);
    host.frame({OPC_RELEASE_ID, 24'h000000}, 32, 16, rd);
    chk(16'(st.deepPd), 16'h0001);
    op(OPC_RELEASE_ID);
    wt(700);
    chk(16'({st.deepPd, st.refuse}), 16'h0003);
    wt(120);
    chk(16'(st), 16'h0000);
    $display("test power-down done");
    qpi = 1'b1;
    param = {2'b10, 2'($urandom), 2'b00, 2'($urandom)};
    host.frame({OPC_SET_PARAM, param}, 16, 0, rd);
    chk(16'(readParam), 16'(param));
    dum = (param[5:4] == 2'b11) ? 8 : (param[5:4] == 2'b10) ? 6 : 4;
    wlen = 8 << param[1:0];
    wa = 24'h000100 + 24'(wlen - 1);
    host.frame(64'({OPC_WRAP_READ, wa}) << (4 * dum), 32 + 4 * dum, 16, rd);
    chk(rd, {8'(wlen - 1) ^ key, key});
    chk(memAddr[15:0], 16'h0102);
    $display("test quad wrap read done");
    op(OPC_EN_RESET);
    op(OPC_RESUME);
    op(OPC_RESET);
    chk(16'({resetCount[1:0], st}), 16'h0000);
    chk(16'(lastFwd), 16'({2'b10, OPC_RESET}));
    op(OPC_EN_RESET);
    op(OPC_RESET);
    chk(16'({resetCount[1:0], st.refuse, readParam}), 16'h0300);
    op(OPC_DEEP_PD);
    wt(400);
    chk(16'(st.deepPd), 16'h0000);
    $display("test soft reset done");
    print_verdict();
  end
endmodule
